/* File: pkg/ism_pkg.sv */
// Constants shared by the interrupt source map and its vector table.
package ism_pkg;
    // ==========================================================
    // Sizes
    localparam int unsigned LINES = 32;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned TBL_AW = 6;

    // ==========================================================
    // Register byte offsets
    localparam logic [11:0] OFF_RAW = 12'h000;
    localparam logic [11:0] OFF_ENABLE = 12'h004;
    localparam logic [11:0] OFF_PRIO_LO = 12'h008;
    localparam logic [11:0] OFF_PRIO_HI = 12'h00C;
    localparam logic [11:0] OFF_NMI_SEL = 12'h010;
    localparam logic [11:0] OFF_NMI_SOFT = 12'h014;
    localparam logic [11:0] OFF_VECTOR_BASE_OFFSET = 12'h018;
    localparam logic [11:0] OFF_STATUS = 12'h01C;
    localparam logic [11:0] OFF_MASK = 12'h020;
    localparam logic [11:0] OFF_CFG = 12'h024;
    localparam logic [3:0] TBL_PAGE = 4'h1;

    // ==========================================================
    // Reset values and field layout
    localparam logic [31:0] VECTOR_BASE_OFFSET_RST = 32'h0000_0000;
    localparam logic [31:0] VECTOR_BASE_OFFSET_MASK = 32'hFFFF_FF80;
    localparam logic [31:0] RSV_MASK = 32'h0070_4262;
    localparam int NMI_SEL_EN = 5;
    localparam int CFG_RISE = 0;
    localparam int CFG_FALL = 1;
    localparam int CFG_BOD_LSB = 2;
    localparam int ST_NMI = 0;
    localparam int ST_CMP = 1;
    localparam int ST_BOD = 2;
    localparam int EVT_W = 3;

    // ==========================================================
    // Line numbers
    localparam int LN_SPI = 0;
    localparam int LN_DAC = 2;
    localparam int LN_UART0 = 3;
    localparam int LN_UART1 = 4;
    localparam int LN_I2C1 = 7;
    localparam int LN_I2C0 = 8;
    localparam int LN_MRT = 10;
    localparam int LN_SHARED = 11;
    localparam int LN_WDT = 12;
    localparam int LN_BOD = 13;
    localparam int LN_WKT = 15;
    localparam int LN_ADC = 16;
    localparam int LN_CTMR = 23;
    localparam int LN_PIN = 24;

    // ==========================================================
    // Exception numbers and bus answers
    localparam logic [5:0] EXC_NMI = 6'h02;
    localparam logic [5:0] EXC_IRQ_BASE = 6'h10;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_FETCH = 2'h1,
        ST_PRESENT = 2'h3
    } ism_state_t;
endpackage

/* File: verilog/ism_vector_table.sv */
// Small vector table memory with one write port and two registered read ports.
`timescale 1ns/1ns
module ism_vector_table #(
    parameter int DW = 32,
    parameter int AW = 6
) (
    // Clock
    input wire logic clk_i,
    // Write port
    input wire logic we_i,
    input wire logic [AW-1:0] widx_i,
    input wire logic [DW-1:0] wdata_i,
    // Read port A
    input wire logic a_en_i,
    input wire logic [AW-1:0] a_idx_i,
    output logic [DW-1:0] a_data_o,
    // Read port B
    input wire logic b_en_i,
    input wire logic [AW-1:0] b_idx_i,
    output logic [DW-1:0] b_data_o
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[widx_i] <= wdata_i;
        end
        if (a_en_i) begin
            a_data_o <= mem[a_idx_i];
        end
        if (b_en_i) begin
            b_data_o <= mem[b_idx_i];
        end
    end
endmodule

/* File: verilog/ism_top.sv */
// Interrupt line map, NMI source select and relocatable vector dispatch.
// Operation
// RQ1: Line 10 is high while any of the four timer channel flags is set.
// RQ2: Line 11 is shared by comparator and touch requests.
// RQ3: Comparator edge flag is set on rising, falling or both edges as configured.
// RQ4: Line 12 follows the watchdog warning flag.
// RQ5: Line 13 follows the selected brown-out level crossing.
// RQ6: ADC drives lines 16, 17, 18 and 19 separately.
// RQ7: Lines 24 to 31 follow pin event status bits 0 to 7.
// RQ8: NMI is raised by a selected line or by software.
// RQ9: NMI wins over every other exception except reset.
// RQ10: A select register routes any one line to the NMI.
// RQ11: Software disables a line's ordinary enable while it is routed to NMI.
// RQ12: Vector table holds initial stack pointer then handler addresses.
// RQ13: Vector table base is zero after reset.
// RQ14: A writable offset register relocates every vector fetch; the table fetch index uses only offset bits 7:2, so only bit 7 moves it.
// RQ15: Equal priority requests are served lowest line number first.
// RQ16: Thirty-two lines, each with a 2-bit priority of four levels.
// RQ17: Reserved lines 5, 6, 9, 14, 20, 21, 22 never raise requests.
// RQ18: Lines 7, 8, 15, 23 carry I2C1, I2C0, wake-up alarm, counter timer.
`timescale 1ns/1ns
module ism_top (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    // AXI4-Lite slave
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [11:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // Peripheral requests on the system clock
    input wire logic spi_request_i,
    input wire logic dac_request_i,
    input wire logic uart0_request_i,
    input wire logic uart1_request_i,
    input wire logic i2c_port1_request_i,
    input wire logic i2c_port0_request_i,
    input wire logic [3:0] mrt_channel_flag_i,
    input wire logic touch_sense_request_i,
    input wire logic watchdog_warning_flag_i,
    input wire logic wakeup_alarm_flag_i,
    input wire logic adc_seq_a_done_i,
    input wire logic adc_seq_b_done_i,
    input wire logic adc_threshold_hit_i,
    input wire logic adc_overrun_i,
    input wire logic counter_timer_request_i,
    input wire logic [7:0] pin_event_status_i,
    // Analog levels from outside the clock domain
    input wire logic comparator_level_i,
    input wire logic [3:0] brownout_level_i,
    // Core exception entry
    output logic exc_valid_o,
    output logic [5:0] exc_num_o,
    output logic [31:0] exc_vector_addr_o,
    output logic [31:0] exc_handler_o,
    input wire logic exc_ack_i,
    output logic nmi_o,
    output logic irq_o
);
    typedef struct packed {
        logic aw_have;
        logic [11:0] aw_addr;
        logic w_have;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic ar_busy;
        logic rd_stage;
        logic [11:0] ar_addr;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [31:0] line;
        logic [31:0] enable;
        logic [63:0] prio;
        logic [5:0] nmi_sel;
        logic soft_nmi;
        logic [31:0] vector_base_offset;
        logic [2:0] status;
        logic [2:0] mask;
        logic [3:0] cfg;
        logic cmp_m;
        logic cmp_s;
        logic cmp_d;
        logic [3:0] bod_m;
        logic [3:0] bod_s;
        logic bod_d;
        ism_pkg::ism_state_t state;
        logic [5:0] exc_num;
        logic exc_valid;
        logic [31:0] exc_handler;
        logic [31:0] exc_addr;
        logic nmi;
        logic irq;
    } ism_regs_t;

    // ==========================================================
    // Reset release
    logic [1:0] rst_q;
    logic rst_n;

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_q <= 2'h0;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_n = rst_q[1];

    // ==========================================================
    // Vector table
    ism_regs_t s;
    ism_regs_t n;
    logic mem_we;
    logic [5:0] mem_widx;
    logic [31:0] mem_wdata;
    logic rd_a_en;
    logic [5:0] rd_a_idx;
    logic [31:0] rd_a_data;
    logic rd_b_en;
    logic [5:0] rd_b_idx;
    logic [31:0] rd_b_data;
    logic nmi_act;

    ism_vector_table #(.DW(32), .AW(ism_pkg::TBL_AW)) u_table (
        .clk_i(sys_clk_i),
        .we_i(mem_we),
        .widx_i(mem_widx),
        .wdata_i(mem_wdata),
        .a_en_i(rd_a_en),
        .a_idx_i(rd_a_idx),
        .a_data_o(rd_a_data),
        .b_en_i(rd_b_en),
        .b_idx_i(rd_b_idx),
        .b_data_o(rd_b_data)
    );

    function automatic logic [31:0] ism_merge(input logic [31:0] old, input logic [31:0] d,
                                              input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[8*b+:8] = d[8*b+:8];
            end
        end
        return r;
    endfunction

    // ==========================================================
    // Next state
    always_comb begin
        logic [31:0] raw;
        logic [31:0] pend;
        logic [31:0] wm;
        logic [2:0] ev;
        logic [2:0] clr;
        logic bod_sel;
        logic soft_set;
        logic soft_clr;
        logic [1:0] best_pr;
        logic [4:0] best_idx;
        raw = '0;
        pend = '0;
        wm = '0;
        ev = '0;
        clr = '0;
        bod_sel = 1'b0;
        soft_set = 1'b0;
        soft_clr = 1'b0;
        best_pr = 2'h3;
        best_idx = 5'h0;
        n = s;
        mem_we = 1'b0;
        mem_widx = '0;
        mem_wdata = '0;
        rd_a_en = 1'b0;
        rd_a_idx = '0;
        rd_b_en = 1'b0;
        rd_b_idx = '0;
        // The first stage of each synchroniser feeds only the second.
        n.cmp_m = comparator_level_i;
        n.cmp_s = s.cmp_m;
        n.cmp_d = s.cmp_s;
        n.bod_m = brownout_level_i;
        n.bod_s = s.bod_m;
        bod_sel = s.bod_s[s.cfg[ism_pkg::CFG_BOD_LSB+:2]];
        n.bod_d = bod_sel;
        // RQ3 comparator edge select.
        ev[ism_pkg::ST_CMP] = (s.cmp_s & ~s.cmp_d & s.cfg[ism_pkg::CFG_RISE])
                            | (~s.cmp_s & s.cmp_d & s.cfg[ism_pkg::CFG_FALL]);
        ev[ism_pkg::ST_BOD] = bod_sel & ~s.bod_d;
        raw[ism_pkg::LN_SPI] = spi_request_i;
        raw[ism_pkg::LN_DAC] = dac_request_i;
        raw[ism_pkg::LN_UART0] = uart0_request_i;
        raw[ism_pkg::LN_UART1] = uart1_request_i;
        // RQ18 fixed peripheral lines.
        raw[ism_pkg::LN_I2C1] = i2c_port1_request_i;
        raw[ism_pkg::LN_I2C0] = i2c_port0_request_i;
        raw[ism_pkg::LN_WKT] = wakeup_alarm_flag_i;
        raw[ism_pkg::LN_CTMR] = counter_timer_request_i;
        // RQ1 timer global line.
        raw[ism_pkg::LN_MRT] = |mrt_channel_flag_i;
        // RQ2 shared comparator line.
        raw[ism_pkg::LN_SHARED] = s.status[ism_pkg::ST_CMP] | touch_sense_request_i;
        // RQ4 watchdog warning line.
        raw[ism_pkg::LN_WDT] = watchdog_warning_flag_i;
        // RQ5 brown-out level line.
        raw[ism_pkg::LN_BOD] = bod_sel;
        // RQ6 four ADC lines.
        raw[ism_pkg::LN_ADC+:4] = {adc_overrun_i, adc_threshold_hit_i,
                                   adc_seq_b_done_i, adc_seq_a_done_i};
        // RQ7 pin event lines.
        raw[ism_pkg::LN_PIN+:8] = pin_event_status_i;
        // RQ17 reserved lines held low.
        n.line = raw & ~ism_pkg::RSV_MASK;
        // RQ16 priority scan; RQ15 ties go to the lower line.
        pend = s.line & s.enable;
        for (int i = int'(ism_pkg::LINES) - 1; i >= 0; i--) begin
            if (pend[i] && s.prio[2*i+:2] <= best_pr) begin
                best_pr = s.prio[2*i+:2];
                best_idx = 5'(i);
            end
        end
        n.nmi = nmi_act;
        // RQ12 vector fetch from the table; RQ9 NMI is picked first.
        case (s.state)
            ism_pkg::ST_IDLE: begin
                if (nmi_act || (|pend)) begin
                    n.exc_num = nmi_act ? ism_pkg::EXC_NMI
                                        : ism_pkg::EXC_IRQ_BASE + {1'b0, best_idx};
                    rd_b_en = 1'b1;
                    rd_b_idx = s.vector_base_offset[7:2] + n.exc_num;
                    // RQ14 relocated vector address.
                    n.exc_addr = s.vector_base_offset + {24'h0, n.exc_num, 2'h0};
                    n.state = ism_pkg::ST_FETCH;
                end
            end
            ism_pkg::ST_FETCH: begin
                n.exc_handler = rd_b_data;
                n.exc_valid = 1'b1;
                n.state = ism_pkg::ST_PRESENT;
            end
            ism_pkg::ST_PRESENT: begin
                if (exc_ack_i) begin
                    n.exc_valid = 1'b0;
                    n.state = ism_pkg::ST_IDLE;
                    if (s.exc_num == ism_pkg::EXC_NMI) begin
                        soft_clr = 1'b1;
                        ev[ism_pkg::ST_NMI] = 1'b1;
                    end
                end
            end
            default: begin
                n.exc_valid = 1'b0;
                n.state = ism_pkg::ST_IDLE;
            end
        endcase
        // Write channel: address and data are taken in either order.
        if (s.awready && s_axi_awvalid) begin
            n.aw_have = 1'b1;
            n.aw_addr = s_axi_awaddr;
        end
        if (s.wready && s_axi_wvalid) begin
            n.w_have = 1'b1;
            n.w_data = s_axi_wdata;
            n.w_strb = s_axi_wstrb;
        end
        if (s.aw_have && s.w_have && !s.bvalid) begin
            n.aw_have = 1'b0;
            n.w_have = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = ism_pkg::RESP_OKAY;
            wm = ism_merge(32'h0, s.w_data, s.w_strb);
            case (s.aw_addr)
                ism_pkg::OFF_RAW: begin
                    n.bresp = ism_pkg::RESP_OKAY;
                end
                ism_pkg::OFF_ENABLE: n.enable = ism_merge(s.enable, s.w_data, s.w_strb);
                ism_pkg::OFF_PRIO_LO: n.prio[31:0] = ism_merge(s.prio[31:0], s.w_data, s.w_strb);
                ism_pkg::OFF_PRIO_HI: n.prio[63:32] = ism_merge(s.prio[63:32], s.w_data, s.w_strb);
                // RQ10 NMI source select.
                ism_pkg::OFF_NMI_SEL: begin
                    if (s.w_strb[0]) begin
                        n.nmi_sel = s.w_data[5:0];
                    end
                end
                ism_pkg::OFF_NMI_SOFT: soft_set = wm[0];
                ism_pkg::OFF_VECTOR_BASE_OFFSET: begin
                    n.vector_base_offset = ism_merge(s.vector_base_offset, s.w_data, s.w_strb) & ism_pkg::VECTOR_BASE_OFFSET_MASK;
                end
                ism_pkg::OFF_STATUS: clr = wm[ism_pkg::EVT_W-1:0];
                ism_pkg::OFF_MASK: begin
                    if (s.w_strb[0]) begin
                        n.mask = s.w_data[ism_pkg::EVT_W-1:0];
                    end
                end
                ism_pkg::OFF_CFG: begin
                    if (s.w_strb[0]) begin
                        n.cfg = s.w_data[3:0];
                    end
                end
                default: begin
                    if (s.aw_addr[11:8] == ism_pkg::TBL_PAGE && s.w_strb == 4'hF) begin
                        mem_we = 1'b1;
                        mem_widx = s.aw_addr[7:2];
                        mem_wdata = s.w_data;
                    end else if (s.aw_addr[11:8] != ism_pkg::TBL_PAGE) begin
                        n.bresp = ism_pkg::RESP_SLVERR;
                    end
                end
            endcase
        end
        if (s.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
        end
        n.awready = ~n.aw_have & ~n.bvalid;
        n.wready = ~n.w_have & ~n.bvalid;
        // Read channel: table reads need one cycle, so every read takes two.
        if (s.arready && s_axi_arvalid) begin
            n.ar_busy = 1'b1;
            n.rd_stage = 1'b1;
            n.ar_addr = s_axi_araddr;
            rd_a_en = 1'b1;
            rd_a_idx = s_axi_araddr[7:2];
        end
        if (s.rd_stage) begin
            n.rd_stage = 1'b0;
            n.rvalid = 1'b1;
            n.rresp = ism_pkg::RESP_OKAY;
            case (s.ar_addr)
                ism_pkg::OFF_RAW: n.rdata = s.line;
                ism_pkg::OFF_ENABLE: n.rdata = s.enable;
                ism_pkg::OFF_PRIO_LO: n.rdata = s.prio[31:0];
                ism_pkg::OFF_PRIO_HI: n.rdata = s.prio[63:32];
                ism_pkg::OFF_NMI_SEL: n.rdata = {26'h0, s.nmi_sel};
                ism_pkg::OFF_NMI_SOFT: n.rdata = {31'h0, s.soft_nmi};
                ism_pkg::OFF_VECTOR_BASE_OFFSET: n.rdata = s.vector_base_offset;
                ism_pkg::OFF_STATUS: n.rdata = {29'h0, s.status};
                ism_pkg::OFF_MASK: n.rdata = {29'h0, s.mask};
                ism_pkg::OFF_CFG: n.rdata = {28'h0, s.cfg};
                default: begin
                    n.rdata = (s.ar_addr[11:8] == ism_pkg::TBL_PAGE) ? rd_a_data : 32'h0;
                    if (s.ar_addr[11:8] != ism_pkg::TBL_PAGE) begin
                        n.rresp = ism_pkg::RESP_SLVERR;
                    end
                end
            endcase
        end
        if (s.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
            n.ar_busy = 1'b0;
        end
        n.arready = ~n.ar_busy;
        // A new event beats a clear in the same cycle.
        n.status = (s.status & ~clr) | ev;
        n.soft_nmi = (s.soft_nmi & ~soft_clr) | soft_set;
        n.irq = |(s.status & s.mask);
    end

    // RQ8 NMI from selected line or software; RQ11 relies on software disabling that line.
    assign nmi_act = s.soft_nmi | (s.nmi_sel[ism_pkg::NMI_SEL_EN] & s.line[s.nmi_sel[4:0]]);

    // RQ13 state clears to zero, so the vector base starts at address zero.
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign s_axi_awready = s.awready;
    assign s_axi_wready = s.wready;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_arready = s.arready;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rdata = s.rdata;
    assign s_axi_rresp = s.rresp;
    assign exc_valid_o = s.exc_valid;
    assign exc_num_o = s.exc_num;
    assign exc_vector_addr_o = s.exc_addr;
    assign exc_handler_o = s.exc_handler;
    assign nmi_o = s.nmi;
    assign irq_o = s.irq;

    // ==========================================================
    // Checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n);

    a_reserved_quiet: assert property ((s.line & ism_pkg::RSV_MASK) == 32'h0) // RQ17
        else $error("reserved line raised");
    a_timer_global: assert property (##1 s.line[ism_pkg::LN_MRT] == // RQ1
            $past(|mrt_channel_flag_i))
        else $error("timer line wrong");
    a_shared_line: assert property (##1 s.line[ism_pkg::LN_SHARED] == // RQ2
            $past(s.status[ism_pkg::ST_CMP] | touch_sense_request_i))
        else $error("shared line wrong");
    a_edge_rise: assert property (s.cmp_s && !s.cmp_d && s.cfg[ism_pkg::CFG_RISE] // RQ3
            |=> s.status[ism_pkg::ST_CMP])
        else $error("rising edge flag missed");
    a_adc_lines: assert property (##1 s.line[19:16] == $past({adc_overrun_i, // RQ6
            adc_threshold_hit_i, adc_seq_b_done_i, adc_seq_a_done_i}))
        else $error("adc lines wrong");
    a_pin_lines: assert property (##1 s.line[31:24] == $past(pin_event_status_i)) // RQ7
        else $error("pin lines wrong");
    a_nmi_first: assert property (s.state == ism_pkg::ST_IDLE && nmi_act // RQ9
            |=> s.state == ism_pkg::ST_FETCH && s.exc_num == ism_pkg::EXC_NMI)
        else $error("nmi not taken first");
    a_nmi_route: assert property (s.nmi_sel[ism_pkg::NMI_SEL_EN] && s.line[s.nmi_sel[4:0]] // RQ10
            |=> nmi_o)
        else $error("routed line missed nmi");
    a_vector_reloc: assert property (s.state == ism_pkg::ST_FETCH // RQ14
            |-> s.exc_addr == $past(s.vector_base_offset) + {24'h0, s.exc_num, 2'h0})
        else $error("vector address not relocated");
endmodule

/* File: sim/ism_core_model.sv */
// Behavioural model of the core's exception entry handshake.
`timescale 1ns/1ns
module ism_core_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Exception entry
    input wire logic exc_valid_i,
    input wire logic slow_i,
    output logic ack_o
);
    logic [2:0] wait_cnt;

    // exception entry taken
    // A slow core lets the request stand for a few cycles before taking it.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wait_cnt <= 3'h0;
            ack_o <= 1'b0;
        end else begin
            ack_o <= 1'b0;
            if (exc_valid_i && !ack_o) begin
                if (wait_cnt >= (slow_i ? 3'h3 : 3'h0)) begin
                    ack_o <= 1'b1;
                    wait_cnt <= 3'h0;
                end else begin
                    wait_cnt <= wait_cnt + 3'h1;
                end
            end
        end
    end
endmodule

/* File: sim/tb_top.sv */
// Self-checking bench for the interrupt source map.
`timescale 1ns/1ns
module tb_top;
    logic clk, rst_b, awv, awr, wv, wrdy, bv, bre, arv, arr, rv, rre, cmp, slow, ack;
    logic exc_v, nmi, irq;
    logic [11:0] awa, ara;
    logic [31:0] wd, rdat, rd_d, p, lf, va, hd;
    logic [1:0] resp, br, rr;
    logic [3:0] bod;
    logic [5:0] num;
    int error_cnt, total_checks, cyc;

    // ==========================================================
    // Clock, design and core model
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    ism_top u_dut (.sys_clk_i(clk), .rst_b_i(rst_b),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
        .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
        .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_bresp(br),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
        .s_axi_rvalid(rv), .s_axi_rready(rre), .s_axi_rdata(rd_d), .s_axi_rresp(rr),
        .spi_request_i(p[0]), .dac_request_i(p[2]), .uart0_request_i(p[3]),
        .uart1_request_i(p[4]), .i2c_port1_request_i(p[7]), .i2c_port0_request_i(p[8]),
        .mrt_channel_flag_i(p[12:9]), .touch_sense_request_i(p[13]),
        .watchdog_warning_flag_i(p[14]), .wakeup_alarm_flag_i(p[15]),
        .adc_seq_a_done_i(p[16]), .adc_seq_b_done_i(p[17]), .adc_threshold_hit_i(p[18]),
        .adc_overrun_i(p[19]), .counter_timer_request_i(p[23]),
        .pin_event_status_i(p[31:24]), .comparator_level_i(cmp), .brownout_level_i(bod),
        .exc_valid_o(exc_v), .exc_num_o(num), .exc_vector_addr_o(va),
        .exc_handler_o(hd), .exc_ack_i(ack), .nmi_o(nmi), .irq_o(irq));

    ism_core_model u_core (.clk_i(clk), .rst_b_i(rst_b), .exc_valid_i(exc_v),
        .slow_i(slow), .ack_o(ack));

    // ==========================================================
    // Helpers
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [31:0] exp_raw(input logic [31:0] s);
        logic [31:0] e;
        e = s & 32'hFF8F_819D;
        e[10] = |s[12:9];
        e[11] = s[13];
        e[12] = s[14];
        return e;
    endfunction

    task automatic wrap_up();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        awv <= 1'b1;
        wv <= 1'b1;
        awa <= a;
        wd <= d;
        bre <= 1'b1;
        do begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wrdy) wv <= 1'b0;
        end while (bv !== 1'b1);
        resp = br;
        bre <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a);
        @(posedge clk);
        arv <= 1'b1;
        ara <= a;
        rre <= 1'b1;
        do begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
        end while (rv !== 1'b1);
        rdat = rd_d;
        resp = rr;
        rre <= 1'b0;
    endtask

    // Waits for one presented exception, checks it and removes its source.
    task automatic exc(input logic [5:0] n, input logic [31:0] vt, drop, h);
        int k;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (exc_v !== 1'b1 && k < 60);
        chk(32'(exc_v), 32'h1);
        chk(32'(num), 32'(n));
        chk(va, vt + 32'(n) * 4);
        if (h != 0) chk(hd, h);
        if (n == 6'h02) chk(32'(nmi), 1);
        p <= p & ~drop;
        while (exc_v === 1'b1 && k < 120) begin
            @(posedge clk);
            k++;
        end
    endtask

    // ==========================================================
    // Main sequence
    task automatic run_tests();
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        rd(ism_pkg::OFF_VECTOR_BASE_OFFSET);
        chk(rdat, 32'h0);
        rd(12'h0F0);
        chk(32'(resp), 32'h2);
        wr(12'h0F0, 32'h1);
        chk(32'(resp), 32'h2);
        for (int i = 0; i < 24; i++) begin
            lf = nxt(lf);
            p <= (i == 0) ? 32'hFFFF_FFFF : lf;
            repeat (3) @(posedge clk);
            rd(ism_pkg::OFF_RAW);
            chk(rdat, exp_raw(p));
        end
        p <= 32'h0;
        wr(ism_pkg::OFF_ENABLE, 32'h0000_1008);
        p <= 32'h0000_4008;
        exc(6'h13, 32'h0, 32'h8, 32'h0);
        exc(6'h1C, 32'h0, 32'h4000, 32'h0);
        wr(ism_pkg::OFF_PRIO_LO, 32'h0000_00C0);
        p <= 32'h0000_4008;
        exc(6'h1C, 32'h0, 32'h4000, 32'h0);
        exc(6'h13, 32'h0, 32'h8, 32'h0);
        wr(ism_pkg::OFF_ENABLE, 32'h0000_0008);
        wr(ism_pkg::OFF_NMI_SEL, 32'h0000_002A);
        wr(ism_pkg::OFF_VECTOR_BASE_OFFSET, 32'h0000_0080);
        wr(12'h188, 32'h1234_5670);
        p <= 32'h0000_0208;
        exc(6'h02, 32'h80, 32'h200, 32'h1234_5670);
        exc(6'h13, 32'h80, 32'h8, 32'h0);
        slow <= 1'b1;
        wr(ism_pkg::OFF_NMI_SOFT, 32'h1);
        exc(6'h02, 32'h80, 32'h0, 32'h1234_5670);
        wr(ism_pkg::OFF_ENABLE, 32'h0);
        wr(ism_pkg::OFF_MASK, 32'h6);
        for (int m = 1; m < 4; m++) begin
            wr(ism_pkg::OFF_CFG, 32'(m | (m << 2)));
            wr(ism_pkg::OFF_STATUS, 32'h7);
            cmp <= 1'b1;
            bod <= 4'h1 << m;
            repeat (8) @(posedge clk);
            chk(32'(irq), 32'h1);
            rd(ism_pkg::OFF_STATUS);
            chk(rdat & 32'h6, m[0] ? 32'h6 : 32'h4);
            rd(ism_pkg::OFF_RAW);
            chk(rdat & 32'h2800, m[0] ? 32'h2800 : 32'h2000);
            wr(ism_pkg::OFF_STATUS, 32'h7);
            cmp <= 1'b0;
            bod <= 4'h0;
            repeat (8) @(posedge clk);
            chk(32'(irq), 32'(m[1]));
            rd(ism_pkg::OFF_STATUS);
            chk(rdat & 32'h6, m[1] ? 32'h2 : 32'h0);
        end
    endtask

    initial begin
        {awv, wv, bre, arv, rre, cmp, slow} = 7'h00;
        awa = 12'h000;
        ara = 12'h000;
        wd = 32'h0;
        p = 32'h0;
        bod = 4'h0;
        lf = 32'h04F1;
        rst_b = 1'b0;
        error_cnt = 0;
        total_checks = 0;
        // A hung run runs into the cycle ceiling and is counted as a failure.
        fork
            run_tests();
            begin
                while (cyc < 20000) begin
                    @(posedge clk);
                    cyc++;
                end
                error_cnt++;
            end
        join_any
        wrap_up();
    end
endmodule
